// *** hdl/bibr_pkg.sv ***
package bibr_pkg;

  // AHB-Lite encodings
  localparam int         ADDR_W      = 8;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD  = 3'h2;
  localparam logic       HRESP_OKAY  = 1'h0;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] SIG_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] OPT_OFS = 8'h20;

  // Signature word, ASCII "1394"
  localparam logic [31:0] SIG_VALUE = 32'h3133_3934;

  // Options word field positions
  localparam int IRMC_BIT = 31;
  localparam int CMC_BIT  = 30;
  localparam int ISC_BIT  = 29;
  localparam int BMC_BIT  = 28;
  localparam int PMC_BIT  = 27;
  localparam int RSV0_LSB = 24;
  localparam int CCA_LSB  = 16;
  localparam int MREC_LSB = 12;
  localparam int RSV1_LSB = 8;
  localparam int GEN_LSB  = 6;
  localparam int RSV2_LSB = 3;
  localparam int SPD_LSB  = 0;

  // Fixed and reset field values
  localparam logic [3:0] MREC_RST = 4'hA;
  localparam logic [2:0] SPD_VAL  = 3'h2;
  localparam logic [2:0] RSV0_VAL = 3'h0;
  localparam logic [3:0] RSV1_VAL = 4'h0;
  localparam logic [2:0] RSV2_VAL = 3'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic       irmc;
    logic       cmc;
    logic       isc;
    logic       bmc;
    logic       pmc;
    logic [7:0] cyc_clk_acc;
    logic [3:0] max_rec;
    logic [1:0] gen;
  } bibr_opts_t;

  typedef struct packed {
    logic              dph_wr;
    logic [ADDR_W-1:0] dph_addr;
    bibr_opts_t        opts;
    logic [31:0]       rdata;
    logic              ready;
  } bibr_state_t;

  localparam bibr_opts_t OPTS_RST = '{irmc: 1'h0, cmc: 1'h0, isc: 1'h0, bmc: 1'h0,
                                      pmc: 1'h0, cyc_clk_acc: 8'h00,
                                      max_rec: MREC_RST, gen: 2'h0};

  localparam bibr_state_t ST_RST = '{dph_wr: 1'h0, dph_addr: 8'h00, opts: OPTS_RST,
                                     rdata: 32'h0000_0000, ready: 1'h1};

  function automatic logic [31:0] bibr_pack(input bibr_opts_t o);
    logic [31:0] w;
    w = ZERO_WORD;
    w[IRMC_BIT] = o.irmc;
    w[CMC_BIT] = o.cmc;
    w[ISC_BIT] = o.isc;
    w[BMC_BIT] = o.bmc;
    w[PMC_BIT] = o.pmc;
    w[RSV0_LSB +: 3] = RSV0_VAL;
    w[CCA_LSB +: 8] = o.cyc_clk_acc;
    w[MREC_LSB +: 4] = o.max_rec;
    w[RSV1_LSB +: 4] = RSV1_VAL;
    w[GEN_LSB +: 2] = o.gen;
    w[RSV2_LSB +: 3] = RSV2_VAL;
    w[SPD_LSB +: 3] = SPD_VAL;
    return w;
  endfunction

endpackage

// *** hdl/bibr_regs.sv ***
// Summary of operation
// - The word at 0x1C always reads 0x31333934 and host writes to it are ignored.
// - Options bit 31 is a host-writable resource-manager capability flag, zero after reset.
// - Options bit 30 is a host-writable cycle-master capability flag, zero after reset.
// - Options bit 29 is a host-writable isochronous capability flag, zero after reset.
// - Options bit 28 is a host-writable bus-manager capability flag, zero after reset.
// - Options bit 27 is a host-writable power-management capability flag, zero after reset.
// - The options word at 0x20 mixes writable fields with read-only zero bits 26 to 24, 11 to 8 and 5 to 3.
// - The maximum-request field in bits 15 to 12 resets to 0xA on hardware reset only.
// - Bits 2 to 0 of the options word always read binary 010.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps

module bibr_regs (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic                        soft_reset,
  input  wire logic                        hsel,
  input  wire logic [bibr_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  output bibr_pkg::bibr_opts_t             cap_opts
);

  bibr_pkg::bibr_state_t st_r;
  bibr_pkg::bibr_state_t st_nxt;

  logic addr_acc;
  logic wr_opt;
  logic wr_sig;
  logic rd_sig;
  logic rd_opt;

  // Only NONSEQ and SEQ carry a transfer
  assign addr_acc = hsel && hready && htrans[1];
  assign wr_opt   = st_r.dph_wr && (st_r.dph_addr == bibr_pkg::OPT_OFS);
  assign wr_sig   = st_r.dph_wr && (st_r.dph_addr == bibr_pkg::SIG_OFS);
  assign rd_sig   = addr_acc && !hwrite && (haddr == bibr_pkg::SIG_OFS);
  assign rd_opt   = addr_acc && !hwrite && (haddr == bibr_pkg::OPT_OFS);

  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = 1'h1;
    // Non-word writes are dropped rather than merged by lanes
    st_nxt.dph_wr = addr_acc && hwrite && (hsize == bibr_pkg::HSIZE_WORD);
    st_nxt.dph_addr = haddr;
    if (wr_opt) begin
      st_nxt.opts.irmc = hwdata[bibr_pkg::IRMC_BIT];
      st_nxt.opts.cmc = hwdata[bibr_pkg::CMC_BIT];
      st_nxt.opts.isc = hwdata[bibr_pkg::ISC_BIT];
      st_nxt.opts.bmc = hwdata[bibr_pkg::BMC_BIT];
      st_nxt.opts.pmc = hwdata[bibr_pkg::PMC_BIT];
      st_nxt.opts.cyc_clk_acc = hwdata[bibr_pkg::CCA_LSB +: 8];
      st_nxt.opts.max_rec = hwdata[bibr_pkg::MREC_LSB +: 4];
      st_nxt.opts.gen = hwdata[bibr_pkg::GEN_LSB +: 2];
    end
    if (soft_reset) begin
      st_nxt.opts.irmc = bibr_pkg::OPTS_RST.irmc;
      st_nxt.opts.cmc = bibr_pkg::OPTS_RST.cmc;
      st_nxt.opts.isc = bibr_pkg::OPTS_RST.isc;
      st_nxt.opts.bmc = bibr_pkg::OPTS_RST.bmc;
      st_nxt.opts.pmc = bibr_pkg::OPTS_RST.pmc;
      st_nxt.opts.cyc_clk_acc = bibr_pkg::OPTS_RST.cyc_clk_acc;
      st_nxt.opts.gen = bibr_pkg::OPTS_RST.gen;
    end
    // read mux sees a write completing now
    if (rd_sig) begin
      st_nxt.rdata = bibr_pkg::SIG_VALUE;
    end else if (rd_opt) begin
      st_nxt.rdata = bibr_pkg::bibr_pack(st_nxt.opts);
    end else begin
      st_nxt.rdata = bibr_pkg::ZERO_WORD;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= bibr_pkg::ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = st_r.ready;
  assign hresp     = bibr_pkg::HRESP_OKAY;
  assign hrdata    = st_r.rdata;
  assign cap_opts  = st_r.opts;

  property p_sig_read;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_sig |=> (hrdata == bibr_pkg::SIG_VALUE) && hreadyout;
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("signature read wrong");

  property p_irmc_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_opt && !soft_reset |=> cap_opts.irmc == $past(hwdata[bibr_pkg::IRMC_BIT]);
  endproperty
  a_irmc_wr: assert property (p_irmc_wr) else $error("irmc write lost");

  property p_cmc_soft;
    @(posedge sys_clk) disable iff (!rst_b)
    soft_reset |=> !cap_opts.cmc && !cap_opts.irmc;
  endproperty
  a_cmc_soft: assert property (p_cmc_soft) else $error("cmc not cleared");

  property p_isc_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_opt && !soft_reset |=> cap_opts.isc == $past(hwdata[bibr_pkg::ISC_BIT]);
  endproperty
  a_isc_wr: assert property (p_isc_wr) else $error("isc write lost");

  property p_bmc_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    !wr_opt && !soft_reset |=> $stable(cap_opts.bmc);
  endproperty
  a_bmc_hold: assert property (p_bmc_hold) else $error("bmc changed alone");

  property p_pmc_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_opt && !soft_reset |=> cap_opts.pmc == $past(hwdata[bibr_pkg::PMC_BIT]);
  endproperty
  a_pmc_wr: assert property (p_pmc_wr) else $error("pmc write lost");

  property p_opt_read;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_opt |=> hrdata == bibr_pkg::bibr_pack(cap_opts)
      && hrdata[bibr_pkg::RSV0_LSB +: 3] == bibr_pkg::RSV0_VAL;
  endproperty
  a_opt_read: assert property (p_opt_read) else $error("options read wrong");

  property p_mrec_soft;
    @(posedge sys_clk) disable iff (!rst_b)
    soft_reset && !wr_opt |=> $stable(cap_opts.max_rec);
  endproperty
  a_mrec_soft: assert property (p_mrec_soft) else $error("max_rec hit by soft reset");

  property p_spd_read;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_opt |=> hrdata[bibr_pkg::SPD_LSB +: 3] == bibr_pkg::SPD_VAL;
  endproperty
  a_spd_read: assert property (p_spd_read) else $error("link speed wrong");

  property p_sig_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_sig && !soft_reset |=> $stable(cap_opts);
  endproperty
  a_sig_wr: assert property (p_sig_wr) else $error("signature write had effect");

  property p_cmc_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_opt && !soft_reset |=> cap_opts.cmc == $past(hwdata[bibr_pkg::CMC_BIT]);
  endproperty
  a_cmc_wr: assert property (p_cmc_wr) else $error("cmc write lost");

  property p_bmc_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_opt && !soft_reset |=> cap_opts.bmc == $past(hwdata[bibr_pkg::BMC_BIT]);
  endproperty
  a_bmc_wr: assert property (p_bmc_wr) else $error("bmc write lost");

  property p_cca_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_opt && !soft_reset |=> cap_opts.cyc_clk_acc == $past(hwdata[bibr_pkg::CCA_LSB +: 8]);
  endproperty
  a_cca_wr: assert property (p_cca_wr) else $error("clock accuracy write lost");

  property p_gen_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_opt && !soft_reset |=> cap_opts.gen == $past(hwdata[bibr_pkg::GEN_LSB +: 2]);
  endproperty
  a_gen_wr: assert property (p_gen_wr) else $error("generation write lost");

  property p_mrec_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    wr_opt |=> cap_opts.max_rec == $past(hwdata[bibr_pkg::MREC_LSB +: 4]);
  endproperty
  a_mrec_wr: assert property (p_mrec_wr) else $error("max_rec write lost");

  property p_irmc_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    !wr_opt && !soft_reset |=> $stable(cap_opts.irmc);
  endproperty
  a_irmc_hold: assert property (p_irmc_hold) else $error("irmc changed alone");

  property p_cmc_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    !wr_opt && !soft_reset |=> $stable(cap_opts.cmc);
  endproperty
  a_cmc_hold: assert property (p_cmc_hold) else $error("cmc changed alone");

  property p_isc_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    !wr_opt && !soft_reset |=> $stable(cap_opts.isc);
  endproperty
  a_isc_hold: assert property (p_isc_hold) else $error("isc changed alone");

  property p_pmc_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    !wr_opt && !soft_reset |=> $stable(cap_opts.pmc);
  endproperty
  a_pmc_hold: assert property (p_pmc_hold) else $error("pmc changed alone");

  property p_cca_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    !wr_opt && !soft_reset |=> $stable(cap_opts.cyc_clk_acc) && $stable(cap_opts.gen);
  endproperty
  a_cca_hold: assert property (p_cca_hold) else $error("bus fields changed alone");

  property p_mrec_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    !wr_opt |=> $stable(cap_opts.max_rec);
  endproperty
  a_mrec_hold: assert property (p_mrec_hold) else $error("max_rec changed alone");

  property p_isc_soft;
    @(posedge sys_clk) disable iff (!rst_b)
    soft_reset |=> !cap_opts.isc;
  endproperty
  a_isc_soft: assert property (p_isc_soft) else $error("isc not cleared");

  property p_bmc_soft;
    @(posedge sys_clk) disable iff (!rst_b)
    soft_reset |=> !cap_opts.bmc;
  endproperty
  a_bmc_soft: assert property (p_bmc_soft) else $error("bmc not cleared");

  property p_pmc_soft;
    @(posedge sys_clk) disable iff (!rst_b)
    soft_reset |=> !cap_opts.pmc;
  endproperty
  a_pmc_soft: assert property (p_pmc_soft) else $error("pmc not cleared");

  property p_cca_soft;
    @(posedge sys_clk) disable iff (!rst_b)
    soft_reset |=> cap_opts.cyc_clk_acc == bibr_pkg::OPTS_RST.cyc_clk_acc
      && cap_opts.gen == bibr_pkg::OPTS_RST.gen;
  endproperty
  a_cca_soft: assert property (p_cca_soft) else $error("bus fields not cleared");

  property p_flags_read;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_opt |=> hrdata[bibr_pkg::IRMC_BIT] == cap_opts.irmc && hrdata[bibr_pkg::CMC_BIT] == cap_opts.cmc
      && hrdata[bibr_pkg::ISC_BIT] == cap_opts.isc && hrdata[bibr_pkg::BMC_BIT] == cap_opts.bmc
      && hrdata[bibr_pkg::PMC_BIT] == cap_opts.pmc;
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flags read wrong");

  property p_mrec_read;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_opt |=> hrdata[bibr_pkg::MREC_LSB +: 4] == cap_opts.max_rec;
  endproperty
  a_mrec_read: assert property (p_mrec_read) else $error("max_rec read wrong");

  property p_rsv1_read;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_opt |=> hrdata[bibr_pkg::RSV1_LSB +: 4] == bibr_pkg::RSV1_VAL;
  endproperty
  a_rsv1_read: assert property (p_rsv1_read) else $error("reserved bits 11 to 8 set");

  property p_rsv2_read;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_opt |=> hrdata[bibr_pkg::RSV2_LSB +: 3] == bibr_pkg::RSV2_VAL;
  endproperty
  a_rsv2_read: assert property (p_rsv2_read) else $error("reserved bits 5 to 3 set");

  property p_idle_rdata;
    @(posedge sys_clk) disable iff (!rst_b)
    !rd_sig && !rd_opt |=> hrdata == bibr_pkg::ZERO_WORD;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data not released");

  property p_narrow_wr;
    @(posedge sys_clk) disable iff (!rst_b)
    addr_acc && hwrite && hsize != bibr_pkg::HSIZE_WORD |=> !st_r.dph_wr;
  endproperty
  a_narrow_wr: assert property (p_narrow_wr) else $error("narrow write accepted");

  property p_wr_phase;
    @(posedge sys_clk) disable iff (!rst_b)
    addr_acc && hwrite && hsize == bibr_pkg::HSIZE_WORD |=> st_r.dph_wr
      && st_r.dph_addr == $past(haddr);
  endproperty
  a_wr_phase: assert property (p_wr_phase) else $error("word write not taken");

  property p_hard_rst;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(rst_b) |-> cap_opts == bibr_pkg::OPTS_RST && hrdata == bibr_pkg::ZERO_WORD;
  endproperty
  a_hard_rst: assert property (p_hard_rst) else $error("hardware reset state wrong");

  property p_resp_okay;
    @(posedge sys_clk) disable iff (!rst_b)
    hresp == bibr_pkg::HRESP_OKAY;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("response not okay");

  property p_rdy_high;
    @(posedge sys_clk) disable iff (!rst_b)
    hreadyout;
  endproperty
  a_rdy_high: assert property (p_rdy_high) else $error("wait state inserted");

endmodule

// *** tb/bus_info_block_registers_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module bus_info_block_registers_tb;
  logic                 sys_clk    = 1'b0;
  logic                 rst_b      = 1'b0;
  logic                 soft_reset = 1'b0;
  logic                 hsel       = 1'b0;
  logic [7:0]           haddr      = 8'h00;
  logic [1:0]           htrans     = 2'h0;
  logic                 hwrite     = 1'b0;
  logic [2:0]           hsize      = 3'h2;
  logic [31:0]          hwdata     = 32'h0000_0000;
  logic                 hreadyout;
  logic                 hresp;
  logic [31:0]          hrdata;
  bibr_pkg::bibr_opts_t cap_opts;
  logic [31:0]          rv;
  int                   num_errors = 0;
  int                   checked    = 0;
  // Address, write data, expected read back
  logic [71:0]          rows [10] = '{
    {8'h1C, 32'hFFFF_FFFF, 32'h3133_3934}, {8'h20, 32'hFFFF_FFFF, 32'hF8FF_F0C2},
    {8'h20, 32'h0000_0000, 32'h0000_0002}, {8'h20, 32'h8000_0000, 32'h8000_0002},
    {8'h20, 32'h4000_0000, 32'h4000_0002}, {8'h20, 32'h2000_0000, 32'h2000_0002},
    {8'h20, 32'h1000_0000, 32'h1000_0002}, {8'h20, 32'h0800_0000, 32'h0800_0002},
    {8'h20, 32'h0700_0F3D, 32'h0000_0002}, {8'h20, 32'h0000_5000, 32'h0000_5002}};

  bibr_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .soft_reset(soft_reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cap_opts(cap_opts));

  always #2.5 sys_clk = ~sys_clk;

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        num_errors++;
        report_and_stop();
      end
      @(posedge sys_clk);
    end
  endtask

  // Called just after a rising edge; chained calls run back to back
  task automatic xfer(input logic [7:0] a, input logic w, input logic [2:0] sz,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= bibr_pkg::HTRANS_NSEQ;
    hwrite <= w;
    hsize <= sz;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    `CHK("ready in reset", 1'b1, hreadyout)
    `CHK("read data in reset", 32'h0000_0000, hrdata)
    `CHK("options in reset", bibr_pkg::OPTS_RST, cap_opts)
    rst_b <= 1'b1;
    xfer(8'h20, 1'b0, 3'h2, 32'h0, rv);
    `CHK("options after reset", 32'h0000_A002, rv)
    xfer(8'h1C, 1'b0, 3'h2, 32'h0, rv);
    `CHK("signature", 32'h3133_3934, rv)
    @(posedge sys_clk);
    `CHK("read data released", 32'h0000_0000, hrdata)
    $display("reset test done");
    foreach (rows[i]) begin
      xfer(rows[i][71:64], 1'b1, 3'h2, rows[i][63:32], rv);
      xfer(rows[i][71:64], 1'b0, 3'h2, 32'h0, rv);
      `CHK("row read back", rows[i][31:0], rv)
    end
    $display("row test done");
    // Byte writes are dropped, not merged
    xfer(8'h20, 1'b1, 3'h0, 32'hFFFF_FFFF, rv);
    xfer(8'h20, 1'b0, 3'h2, 32'h0, rv);
    `CHK("narrow write", 32'h0000_5002, rv)
    xfer(8'h40, 1'b0, 3'h2, 32'h0, rv);
    `CHK("unmapped read", 32'h0000_0000, rv)
    `CHK("response", 1'b0, hresp)
    $display("refusal test done");
    xfer(8'h20, 1'b1, 3'h2, 32'hFFFF_FFFF, rv);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    xfer(8'h20, 1'b0, 3'h2, 32'h0, rv);
    `CHK("soft reset", 32'h0000_F002, rv)
    `CHK("soft reset max_rec", 4'hF, cap_opts.max_rec)
    $display("soft reset test done");
    rst_b <= 1'b0;
    @(posedge sys_clk);
    `CHK("options in mid reset", bibr_pkg::OPTS_RST, cap_opts)
    `CHK("read data in mid reset", 32'h0000_0000, hrdata)
    rst_b <= 1'b1;
    xfer(8'h20, 1'b0, 3'h2, 32'h0, rv);
    `CHK("hard reset", 32'h0000_A002, rv)
    `CHK("hard reset flags", 5'h00, cap_opts[18:14])
    $display("hard reset test done");
    report_and_stop();
  end
endmodule
